// ---- hdl/hvr_defines.svh ----
// register offsets, field positions, reset values and timing for the volume/routing block
`ifndef HVR_DEFINES_SVH
`define HVR_DEFINES_SVH

`define HVR_PAGE0           8'h00
`define HVR_PAGE1           8'h01

`define HVR_P0_STEP_REG     7'h3F
`define HVR_P1_HP_PWR_REG   7'h1F
`define HVR_P1_SPK_PWR_REG  7'h20
`define HVR_P1_ROUTE_REG    7'h23
`define HVR_P1_HP_L_REG     7'h24
`define HVR_P1_HP_R_REG     7'h25
`define HVR_P1_SPK_L_REG    7'h26
`define HVR_P1_SPK_R_REG    7'h27
`define HVR_P1_STATUS_REG   7'h46

`define HVR_STEP_LSB        0
`define HVR_STEP_MSB        1
`define HVR_ROUTE_L_BIT     6
`define HVR_ROUTE_R_BIT     2
`define HVR_AMP_ROUTE_BIT   7
`define HVR_PWR_L_BIT       7
`define HVR_PWR_R_BIT       6
`define HVR_PWR_MASK        8'hC0
`define HVR_ROUTE_MASK      8'h44

`define HVR_VOL_RST         8'h7F
`define HVR_CTRL_RST        8'h00
`define HVR_MUTE_CODE       7'h7F
`define HVR_LIN_LAST        7'h23
`define HVR_FLOOR_CODE      7'h75
`define HVR_LIN_STEP        10'h005
`define HVR_FLOOR_ATT       10'h30F
`define HVR_STEP_OFF        2'h3

`define HVR_CLK_MHZ         20
`define HVR_STEP_BASE_NS    20833
`define HVR_STEP_BASE_CYC   ((`HVR_STEP_BASE_NS * `HVR_CLK_MHZ) / 1000)

`endif

// ---- hdl/hvr_pkg.sv ----
// types shared by the volume/routing block
package hvr_pkg;

    typedef enum logic [1:0] {
        HVR_HOLD = 2'h1,
        HVR_STEP = 2'h2
    } hvr_ramp_e;

    typedef logic [6:0] hvr_code_t;

    typedef struct packed {
        logic      pwr_on;
        logic      amp_route;
        logic      mute;
        hvr_code_t code;
        logic [9:0] att_tenths;
    } hvr_drv_s;

endpackage

// ---- hdl/hvr_ramp.sv ----
// soft-step ramp of one driver's applied attenuation code
`timescale 1ns/1ps
`include "hvr_defines.svh"
module hvr_ramp
    import hvr_pkg::*;
(
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rst_n,
    // control
    input  wire hvr_code_t target,
    input  wire logic      tick,
    input  wire logic      bypass,
    // state
    output hvr_code_t      code_q,
    output logic           busy
);

    hvr_ramp_e state_q;
    hvr_ramp_e state_d;
    hvr_code_t code_d;

    always_comb begin
        state_d = state_q;
        code_d  = code_q;
        if (bypass) begin
            code_d  = target;
            state_d = HVR_HOLD;
        end else begin
            case (state_q)
                HVR_HOLD: begin
                    if (target != code_q) begin
                        state_d = HVR_STEP;
                    end
                end
                HVR_STEP: begin
                    // target is compared live, so a new write mid-ramp retargets at once
                    if (target == code_q) begin
                        state_d = HVR_HOLD;
                    end else if (tick) begin
                        code_d = (target > code_q) ? code_q + 7'h01 : code_q - 7'h01; // R15 R07
                        if (code_d == target) begin
                            state_d = HVR_HOLD;
                        end
                    end
                end
                default: state_d = HVR_HOLD;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= HVR_HOLD;
            code_q  <= `HVR_MUTE_CODE;
        end else begin
            state_q <= state_d;
            code_q  <= code_d;
        end
    end

    assign busy = (state_q == HVR_STEP);

    chk_ramp_one_code: assert property (@(posedge clk) disable iff (!rst_n) // R15
        !$past(bypass) |-> (code_q == $past(code_q) || code_q == $past(code_q) + 7'h01
                            || code_q == $past(code_q) - 7'h01))
        else $error("ramp moved by more than one code");

    chk_ramp_toward: assert property (@(posedge clk) disable iff (!rst_n) // R07
        (!bypass && tick && busy && target > code_q) |=> code_q == $past(code_q) + 7'h01)
        else $error("ramp did not step up toward target");

    chk_ramp_bypass: assert property (@(posedge clk) disable iff (!rst_n) // R08
        bypass |=> code_q == $past(target))
        else $error("stepping off but code not applied at once");

endmodule

// ---- hdl/hvr_ctrl.sv ----
// headphone/speaker analog volume, routing, mute and soft-step control
//
// Contract
// R01: software powers the codec clock input, DAC, volume control and driver before expecting a key click.
// R02: headphone and speaker paths run together from the DAC, each at its own volume.
// R03: each unused output driver can be powered down on its own while the others keep running.
// R04: four separate volume settings, one per driver, all applied at the same time.
// R05: volume control stays usable with the audio ADC and DAC powered down.
// R06: headphone attenuation spans 0 dB to about -78 dB in half-dB steps, plus mute.
// R07: volume changes ramp by soft-stepping instead of jumping.
// R08: the soft-step time comes from bits 1..0 of page 0 register 63.
// R09: left DAC feeds left volume control only while page 1 register 35 bit 6 is set.
// R10: right DAC feeds right volume control only while page 1 register 35 bit 2 is set.
// R11: left code is bits 6..0 of page 1 register 36, right code bits 6..0 of register 37.
// R12: volume output reaches the headphone amplifier only while bit 7 of its register is set.
// R13: code maps to a fixed gain: 0.5 dB per code up to 35, then tabulated, 117..127 give -78.3 dB.
// R14: a channel mutes when its routing bit is clear and its code is all ones.
// R15: applied code moves one code per step interval toward the target, retargeting mid-ramp.
`timescale 1ns/1ps
`include "hvr_defines.svh"
module hvr_ctrl
    import hvr_pkg::*;
#(
    parameter int STEP_BASE_CYCLES = `HVR_STEP_BASE_CYC
)
(
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rst_n,
    // register access from the serial control port
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    input  wire logic [7:0]     reg_page,
    input  wire logic [6:0]     reg_addr,
    input  wire logic [7:0]     reg_wdata,
    output logic      [7:0]     reg_rdata,
    // analog routing and drivers: 0 hp left, 1 hp right, 2 spk left, 3 spk right
    output logic                dac_route_l,
    output logic                dac_route_r,
    output hvr_drv_s [3:0]      drv_out
);

    localparam logic [11:0] BASE = 12'(STEP_BASE_CYCLES);

    // attenuation in tenths of a dB for codes 36..116
    localparam logic [9:0] ATT_TBL [0:80] = '{
        181, 186, 191, 196, 201, 206, 211, 216, 221, 226, 231, 236, 241, 246, 251, 256,
        261, 266, 271, 276, 281, 286, 291, 296, 301, 306, 311, 316, 321, 326, 331, 336,
        341, 346, 352, 357, 362, 367, 372, 377, 382, 387, 392, 397, 402, 407, 412, 417,
        421, 427, 432, 438, 443, 448, 452, 458, 462, 467, 474, 479, 482, 487, 493, 500,
        503, 510, 514, 518, 522, 527, 537, 542, 553, 567, 583, 602, 627, 643, 662, 687,
        722};

    generate
        if (STEP_BASE_CYCLES < 1 || STEP_BASE_CYCLES > 1023) begin : g_bad_base
            $error("STEP_BASE_CYCLES must lie in 1..1023");
        end
    endgenerate

    function automatic logic [9:0] att_of(input hvr_code_t c);
        logic [6:0] idx;
        idx = c - 7'h24;
        if (c <= `HVR_LIN_LAST) begin
            att_of = {3'h0, c} * `HVR_LIN_STEP; // R13 R06
        end else if (c >= `HVR_FLOOR_CODE) begin
            att_of = `HVR_FLOOR_ATT; // R13
        end else begin
            att_of = ATT_TBL[idx];
        end
    endfunction

    function automatic logic [11:0] step_len(input logic [1:0] sel);
        step_len = BASE << sel;
    endfunction

    // register state
    logic [7:0] vol_q [4];
    logic [7:0] vol_d [4];
    logic [7:0] route_q;
    logic [7:0] route_d;
    logic [7:0] step_q;
    logic [7:0] step_d;
    logic [7:0] hp_pwr_q;
    logic [7:0] hp_pwr_d;
    logic [7:0] spk_pwr_q;
    logic [7:0] spk_pwr_d;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic       p0;
    logic       p1;

    // ramp state
    logic [11:0] cnt_q;
    logic [11:0] cnt_d;
    logic        tick;
    logic        bypass;
    hvr_code_t   code [4];
    logic [3:0]  busy;
    hvr_drv_s [3:0] drv_d;
    hvr_drv_s [3:0] drv_q;

    assign p0 = (reg_page == `HVR_PAGE0);
    assign p1 = (reg_page == `HVR_PAGE1);

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            vol_d[i] = vol_q[i];
        end
        route_d   = route_q;
        step_d    = step_q;
        hp_pwr_d  = hp_pwr_q;
        spk_pwr_d = spk_pwr_q;
        if (reg_wr) begin
            if (p0 && reg_addr == `HVR_P0_STEP_REG) begin
                step_d = reg_wdata; // R08
            end else if (p1 && reg_addr == `HVR_P1_ROUTE_REG) begin
                route_d = reg_wdata & `HVR_ROUTE_MASK; // R09 R10
            end else if (p1 && reg_addr == `HVR_P1_HP_L_REG) begin
                vol_d[0] = reg_wdata; // R11 R04
            end else if (p1 && reg_addr == `HVR_P1_HP_R_REG) begin
                vol_d[1] = reg_wdata; // R11 R04
            end else if (p1 && reg_addr == `HVR_P1_SPK_L_REG) begin
                vol_d[2] = reg_wdata; // R04 R02
            end else if (p1 && reg_addr == `HVR_P1_SPK_R_REG) begin
                vol_d[3] = reg_wdata; // R04 R02
            end else if (p1 && reg_addr == `HVR_P1_HP_PWR_REG) begin
                hp_pwr_d = reg_wdata & `HVR_PWR_MASK; // R03
            end else if (p1 && reg_addr == `HVR_P1_SPK_PWR_REG) begin
                spk_pwr_d = reg_wdata & `HVR_PWR_MASK; // R03
            end
        end
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            if (p0 && reg_addr == `HVR_P0_STEP_REG) begin
                rdata_d = step_q;
            end else if (p1 && reg_addr == `HVR_P1_ROUTE_REG) begin
                rdata_d = route_q;
            end else if (p1 && reg_addr == `HVR_P1_HP_L_REG) begin
                rdata_d = vol_q[0];
            end else if (p1 && reg_addr == `HVR_P1_HP_R_REG) begin
                rdata_d = vol_q[1];
            end else if (p1 && reg_addr == `HVR_P1_SPK_L_REG) begin
                rdata_d = vol_q[2];
            end else if (p1 && reg_addr == `HVR_P1_SPK_R_REG) begin
                rdata_d = vol_q[3];
            end else if (p1 && reg_addr == `HVR_P1_HP_PWR_REG) begin
                rdata_d = hp_pwr_q;
            end else if (p1 && reg_addr == `HVR_P1_SPK_PWR_REG) begin
                rdata_d = spk_pwr_q;
            end else if (p1 && reg_addr == `HVR_P1_STATUS_REG) begin
                rdata_d = {drv_q[3].mute, drv_q[2].mute, drv_q[1].mute, drv_q[0].mute, busy};
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                vol_q[i] <= `HVR_VOL_RST;
            end
            route_q   <= `HVR_CTRL_RST;
            step_q    <= `HVR_CTRL_RST;
            hp_pwr_q  <= `HVR_CTRL_RST;
            spk_pwr_q <= `HVR_CTRL_RST;
            rdata_q   <= 8'h00;
        end else begin
            for (int i = 0; i < 4; i++) begin
                vol_q[i] <= vol_d[i];
            end
            route_q   <= route_d;
            step_q    <= step_d;
            hp_pwr_q  <= hp_pwr_d;
            spk_pwr_q <= spk_pwr_d;
            rdata_q   <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // one shared step timer keeps all four ramps in lockstep, at the cost of
    // a first step that may come early after a write
    assign bypass = (step_q[`HVR_STEP_MSB:`HVR_STEP_LSB] == `HVR_STEP_OFF);
    assign tick   = (cnt_q == 12'h000);

    always_comb begin
        cnt_d = tick ? step_len(step_q[`HVR_STEP_MSB:`HVR_STEP_LSB]) - 12'h001
                     : cnt_q - 12'h001; // R08
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 12'h000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // ramps run on the codec clock alone, no ADC or DAC power term gates them
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_drv
            hvr_ramp u_ramp (
                .clk    (clk),
                .rst_n  (rst_n),
                .target (vol_q[g][6:0]),
                .tick   (tick),
                .bypass (bypass),
                .code_q (code[g]),
                .busy   (busy[g])
            ); // R05 R07

            chk_gain_floor: assert property (@(posedge clk) disable iff (!rst_n) // R13
                (code[g] >= `HVR_FLOOR_CODE) |=> drv_q[g].att_tenths == `HVR_FLOOR_ATT)
                else $error("floor codes must give the lowest gain");

            chk_gain_linear: assert property (@(posedge clk) disable iff (!rst_n) // R06
                (code[g] <= `HVR_LIN_LAST) |=> drv_q[g].att_tenths == $past(code[g]) * 5)
                else $error("linear range is not half-dB per code");

            chk_mute_decode: assert property (@(posedge clk) disable iff (!rst_n) // R14
                (!vol_q[g][`HVR_AMP_ROUTE_BIT] && vol_q[g][6:0] == `HVR_MUTE_CODE) |=>
                drv_q[g].mute)
                else $error("channel not muted with route clear and code all ones");

            // the four volume registers sit at consecutive addresses, one per driver
            chk_amp_route: assert property (@(posedge clk) disable iff (!rst_n) // R12
                (reg_wr && p1 && reg_addr == 7'(`HVR_P1_HP_L_REG + g)) |=> ##1
                drv_q[g].amp_route == $past(reg_wdata[`HVR_AMP_ROUTE_BIT], 2))
                else $error("amplifier routing does not follow bit 7");
        end
    endgenerate

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            drv_d[i].amp_route  = vol_q[i][`HVR_AMP_ROUTE_BIT]; // R12
            drv_d[i].mute       = !vol_q[i][`HVR_AMP_ROUTE_BIT]
                                  && (vol_q[i][6:0] == `HVR_MUTE_CODE); // R14
            drv_d[i].code       = code[i];
            drv_d[i].att_tenths = att_of(code[i]); // R13
        end
        drv_d[0].pwr_on = hp_pwr_q[`HVR_PWR_L_BIT]; // R03
        drv_d[1].pwr_on = hp_pwr_q[`HVR_PWR_R_BIT];
        drv_d[2].pwr_on = spk_pwr_q[`HVR_PWR_L_BIT];
        drv_d[3].pwr_on = spk_pwr_q[`HVR_PWR_R_BIT];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drv_q <= '0;
        end else begin
            drv_q <= drv_d;
        end
    end

    assign drv_out     = drv_q;
    assign dac_route_l = route_q[`HVR_ROUTE_L_BIT]; // R09
    assign dac_route_r = route_q[`HVR_ROUTE_R_BIT]; // R10

    chk_dac_route_left: assert property (@(posedge clk) disable iff (!rst_n) // R09
        (reg_wr && p1 && reg_addr == `HVR_P1_ROUTE_REG) |=>
        dac_route_l == $past(reg_wdata[`HVR_ROUTE_L_BIT]))
        else $error("left dac routing does not follow bit 6");

    chk_dac_route_right: assert property (@(posedge clk) disable iff (!rst_n) // R10
        (reg_wr && p1 && reg_addr == `HVR_P1_ROUTE_REG) |=>
        dac_route_r == $past(reg_wdata[`HVR_ROUTE_R_BIT]))
        else $error("right dac routing does not follow bit 2");

    // checked on the reload so that a base of one or two cycles stays legal
    chk_step_spacing: assert property (@(posedge clk) disable iff (!rst_n) // R08
        (tick && step_q[`HVR_STEP_MSB:`HVR_STEP_LSB] == 2'h0) |=> cnt_q == BASE - 12'h001)
        else $error("step timer not reloaded with the base interval");

    chk_hp_volume_write: assert property (@(posedge clk) disable iff (!rst_n) // R11
        (reg_wr && p1 && reg_addr == `HVR_P1_HP_R_REG) |=> vol_q[1] == $past(reg_wdata))
        else $error("right headphone volume write lost");

endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for the volume, routing, mute and soft-step control block
`timescale 1ns/1ps
`include "hvr_defines.svh"
module tb_top;
    import hvr_pkg::*;

    localparam int BASE = 4;

    logic              clk;
    logic              rst_n;
    logic              reg_wr;
    logic              reg_rd;
    logic [7:0]        reg_page;
    logic [6:0]        reg_addr;
    logic [7:0]        reg_wdata;
    logic [7:0]        reg_rdata;
    logic              dac_route_l;
    logic              dac_route_r;
    hvr_drv_s [3:0]    drv_out;
    int                fail_count;
    int                n_checks;

    hvr_ctrl #(
        .STEP_BASE_CYCLES (BASE)
    ) i_hvr_ctrl (
        .clk         (clk),
        .rst_n       (rst_n),
        .reg_wr      (reg_wr),
        .reg_rd      (reg_rd),
        .reg_page    (reg_page),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .reg_rdata   (reg_rdata),
        .dac_route_l (dac_route_l),
        .dac_route_r (dac_route_r),
        .drv_out     (drv_out)
    );

    always #25 clk = ~clk;

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // callers enter just after a rising edge; one idle cycle keeps strobes from retoggling
    task automatic wr(input logic [7:0] page, input logic [6:0] addr, input logic [7:0] data);
        reg_wr    = 1'b1;
        reg_page  = page;
        reg_addr  = addr;
        reg_wdata = data;
        @(posedge clk);
        #1 reg_wr = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] page, input logic [6:0] addr, output logic [7:0] data);
        reg_rd   = 1'b1;
        reg_page = page;
        reg_addr = addr;
        @(posedge clk);
        #1 reg_rd = 1'b0;
        @(posedge clk);
        #1 data = reg_rdata;
    endtask

    task automatic settle;
        repeat (4) @(posedge clk);
        #1;
    endtask

    // steps the left headphone code from one value to another, timing every move after the first
    task automatic ramp(input int sel, input logic [6:0] from, input logic [6:0] to);
        logic [6:0] prev;
        int         last_t;
        wr(`HVR_PAGE0, `HVR_P0_STEP_REG, 8'h03);
        wr(`HVR_PAGE1, `HVR_P1_HP_L_REG, {1'b1, from});
        settle();
        wr(`HVR_PAGE0, `HVR_P0_STEP_REG, 8'(sel));
        wr(`HVR_PAGE1, `HVR_P1_HP_L_REG, {1'b1, to});
        prev   = drv_out[0].code;
        last_t = -1;
        for (int i = 0; i < 2000 && drv_out[0].code !== to; i++) begin
            @(posedge clk);
            #1;
            if (drv_out[0].code !== prev) begin
                chk("ramp step", drv_out[0].code, (from < to) ? prev + 7'h01 : prev - 7'h01);
                if (last_t >= 0)
                    chk("step interval", 16'(i - last_t), 16'(BASE << sel));
                last_t = i;
                prev   = drv_out[0].code;
            end
        end
        chk("ramp end", drv_out[0].code, to);
        chk("ramp seen", 16'(last_t >= 0), 16'(from != to));
    endtask

    logic [7:0]  rv;
    logic [6:0]  codes [10] = '{7'd0, 7'd1, 7'd35, 7'd36, 7'd60, 7'd87, 7'd110, 7'd116,
                                7'd117, 7'd126};
    logic [9:0]  atts  [10] = '{10'd0, 10'd5, 10'd175, 10'd181, 10'd301, 10'd438, 10'd583,
                                10'd722, 10'd783, 10'd783};
    logic [6:0]  peak;

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_page = 8'h00;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
        fail_count = 0;
        n_checks = 0;
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        @(posedge clk);
        #1;
        settle();

        chk("hp l code at reset", drv_out[0].code, 16'h007F);
        chk("hp l att at reset", drv_out[0].att_tenths, 16'd783);
        chk("hp l mute at reset", drv_out[0].mute, 16'h0001);
        rd(`HVR_PAGE1, `HVR_P1_HP_L_REG, rv);
        chk("hp l reg reset", rv, 16'h007F);
        rd(`HVR_PAGE1, `HVR_P1_ROUTE_REG, rv);
        chk("route reg reset", rv, 16'h0000);
        rd(`HVR_PAGE1, 7'h10, rv);
        chk("unmapped read", rv, 16'h0000);
        rd(`HVR_PAGE1, `HVR_P1_STATUS_REG, rv);
        chk("status at reset", rv, 16'h00F0);
        $display("test reset done");

        // routing bits read back as written and reserved bits read back as zero
        wr(`HVR_PAGE1, `HVR_P1_ROUTE_REG, 8'hFF);
        rd(`HVR_PAGE1, `HVR_P1_ROUTE_REG, rv);
        chk("route reg mask", rv, 16'h0044);
        wr(`HVR_PAGE1, `HVR_P1_ROUTE_REG, 8'h40);
        chk("route l only", {dac_route_l, dac_route_r}, 16'h0002);
        wr(`HVR_PAGE1, `HVR_P1_ROUTE_REG, 8'h04);
        chk("route r only", {dac_route_l, dac_route_r}, 16'h0001);
        $display("test routing done");

        wr(`HVR_PAGE1, `HVR_P1_HP_PWR_REG, 8'h80);
        wr(`HVR_PAGE1, `HVR_P1_SPK_PWR_REG, 8'h40);
        settle();
        chk("power pattern", {drv_out[3].pwr_on, drv_out[2].pwr_on, drv_out[1].pwr_on,
            drv_out[0].pwr_on}, 16'h0009);
        $display("test power done");

        // gain table with stepping bypassed
        wr(`HVR_PAGE0, `HVR_P0_STEP_REG, 8'h03);
        for (int k = 0; k < 10; k++) begin
            wr(`HVR_PAGE1, `HVR_P1_HP_L_REG, {1'b1, codes[k]});
            settle();
            chk("gain code", drv_out[0].code, codes[k]);
            chk("gain att", drv_out[0].att_tenths, atts[k]);
        end
        rd(`HVR_PAGE1, `HVR_P1_HP_L_REG, rv);
        chk("vol reg all bits", rv, 16'h00FE);
        $display("test gain table done");

        wr(`HVR_PAGE1, `HVR_P1_HP_R_REG, 8'h7F);
        settle();
        chk("mute on", {drv_out[1].mute, drv_out[1].amp_route}, 16'h0002);
        wr(`HVR_PAGE1, `HVR_P1_HP_R_REG, 8'hFF);
        settle();
        chk("routed full code", {drv_out[1].mute, drv_out[1].amp_route}, 16'h0001);
        wr(`HVR_PAGE1, `HVR_P1_HP_R_REG, 8'h7E);
        settle();
        chk("unrouted not mute", {drv_out[1].mute, drv_out[1].amp_route}, 16'h0000);
        $display("test mute done");

        wr(`HVR_PAGE1, `HVR_P1_HP_L_REG, 8'h8A);
        wr(`HVR_PAGE1, `HVR_P1_HP_R_REG, 8'h9E);
        wr(`HVR_PAGE1, `HVR_P1_SPK_L_REG, 8'h94);
        wr(`HVR_PAGE1, `HVR_P1_SPK_R_REG, 8'h28);
        settle();
        chk("hp l own", drv_out[0].code, 16'd10);
        chk("hp r own", drv_out[1].code, 16'd30);
        chk("spk l own", drv_out[2].code, 16'd20);
        chk("spk r own", drv_out[3].code, 16'd40);
        chk("amp routes", {drv_out[3].amp_route, drv_out[2].amp_route, drv_out[1].amp_route,
            drv_out[0].amp_route}, 16'h0007);
        $display("test independent volumes done");

        // converters off: routing cleared, volume still steps
        wr(`HVR_PAGE1, `HVR_P1_ROUTE_REG, 8'h00);
        ramp(0, 7'd10, 7'd20);
        ramp(1, 7'd30, 7'd25);
        ramp(2, 7'd5, 7'd9);
        $display("test soft step done");

        ramp(0, 7'd10, 7'd10);
        wr(`HVR_PAGE1, `HVR_P1_HP_L_REG, 8'hA8);
        for (int i = 0; i < 500 && drv_out[0].code < 7'd15; i++) begin
            @(posedge clk);
            #1;
        end
        wr(`HVR_PAGE1, `HVR_P1_HP_L_REG, 8'h8C);
        peak = drv_out[0].code;
        for (int i = 0; i < 500 && drv_out[0].code !== 7'd12; i++) begin
            @(posedge clk);
            #1;
            if (drv_out[0].code > peak)
                peak = drv_out[0].code;
        end
        chk("retarget end", drv_out[0].code, 16'd12);
        chk("retarget overshoot", 16'(peak <= 7'd17), 16'h0001);
        $display("test retarget done");
        wrap_up();
    end

    initial begin
        #1_000_000;
        fail_count++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        wrap_up();
    end
endmodule
